// ==== design/oplm_cmp.sv ====
`timescale 1ns/1ps
module oplm_cmp (
   input  wire logic i_core_clk,
   input  wire logic i_srst,
   oplm_cmp_if.cmp   bus
);
   oplm_pkg::oplm_cmp_state_t st_ff;
   oplm_pkg::oplm_cmp_state_t nxt_st;

   // signed compare, so negative temperatures order correctly
   always_comb begin
      nxt_st       = st_ff;
      nxt_st.vld   = bus.vld;
      if (bus.vld) begin
         nxt_st.below = $signed(bus.value) < $signed(bus.lo);
         nxt_st.above = $signed(bus.value) > $signed(bus.hi);
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (i_srst) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign bus.out_vld = st_ff.vld;
   assign bus.below   = st_ff.below;
   assign bus.above   = st_ff.above;
endmodule : oplm_cmp

// ==== design/oplm_cmp_if.sv ====
`timescale 1ns/1ps
interface oplm_cmp_if #(parameter int W = 32);
   logic         vld;
   logic [W-1:0] value;
   logic [W-1:0] lo;
   logic [W-1:0] hi;
   logic         out_vld;
   logic         below;
   logic         above;
   modport mon (output vld, value, lo, hi, input out_vld, below, above);
   modport cmp (input vld, value, lo, hi, output out_vld, below, above);
endinterface : oplm_cmp_if

// ==== design/oplm_pkg.sv ====
package oplm_pkg;
   localparam int          ADDR_W          = 8;
   localparam int          NUM_CH          = 4;
   localparam int          EVT_W           = 6;
   // register byte offsets
   localparam logic [7:0]  OFS_CTRL        = 8'h00;
   localparam logic [7:0]  OFS_STAT        = 8'h04;
   localparam logic [7:0]  OFS_EVT         = 8'h08;
   localparam logic [7:0]  OFS_MASK        = 8'h0c;
   localparam logic [7:0]  OFS_TEMP_LO     = 8'h10;
   localparam logic [7:0]  OFS_TEMP_HI     = 8'h14;
   localparam logic [7:0]  OFS_VOLT_LIM    = 8'h18;
   localparam logic [7:0]  OFS_CURR_LIM    = 8'h1c;
   localparam logic [7:0]  OFS_RES_LO      = 8'h20;
   localparam logic [7:0]  OFS_RES_HI      = 8'h24;
   localparam logic [7:0]  OFS_SETP        = 8'h28;
   localparam logic [7:0]  OFS_MEAS_TEMP   = 8'h2c;
   localparam logic [7:0]  OFS_MEAS_VOLT   = 8'h30;
   localparam logic [7:0]  OFS_MEAS_CURR   = 8'h34;
   localparam logic [7:0]  OFS_MEAS_RES    = 8'h38;
   // event register bits
   localparam int          BIT_OVER_TEMP   = 0;
   localparam int          BIT_UNDER_TEMP  = 1;
   localparam int          BIT_OVER_VOLT   = 2;
   localparam int          BIT_CURR_OVFL   = 3;
   localparam int          BIT_OVER_RES    = 4;
   localparam int          BIT_UNDER_RES   = 5;
   // control and status bits
   localparam int          CTRL_OUT_ON     = 0;
   localparam int          CTRL_DEFAULTS   = 1;
   localparam int          CTRL_FUNC_LSB   = 2;
   localparam int          CTRL_SENS_LSB   = 4;
   localparam int          STAT_OUT_ON     = 0;
   localparam int          STAT_TEMP_VIOL  = 1;
   localparam int          STAT_RES_VIOL   = 2;
   localparam int          STAT_ON_REFUSED = 3;
   localparam int          STAT_WR_REJECT  = 4;
   // comparator channels
   localparam int          CH_TEMP         = 0;
   localparam int          CH_VOLT         = 1;
   localparam int          CH_CURR         = 2;
   localparam int          CH_RES          = 3;
   // limits: temperature in m degC, voltage in mV, current in mA, resistance in m ohm
   localparam logic [31:0] TEMP_MIN        = 32'hffff3cb0;
   localparam logic [31:0] TEMP_MAX        = 32'h0003d090;
   localparam logic [31:0] VOLT_MIN        = 32'h000001f4;
   localparam logic [31:0] VOLT_MAX        = 32'h00002904;
   localparam logic [31:0] CURR_MIN        = 32'h000003e8;
   localparam logic [31:0] CURR_MAX        = 32'h00001482;
   localparam logic [31:0] SIGNED_MIN      = 32'h80000000;
   // reset and restore-default values
   localparam logic [31:0] TEMP_LO_DEF     = 32'hffff3cb0;
   localparam logic [31:0] TEMP_HI_DEF     = 32'h0003d090;
   localparam logic [31:0] VOLT_LIM_DEF    = 32'h00002904;
   localparam logic [31:0] CURR_LIM_DEF    = 32'h000007d0;
   localparam logic [31:0] RES_LO_DEF      = 32'h000003e8;
   localparam logic [31:0] RES_HI_DEF      = 32'h0bebc200;
   localparam logic [31:0] SETP_DEF        = 32'h00000000;

   typedef enum logic [1:0] {
      FUNC_TEMP = 2'h0,
      FUNC_VOLT = 2'h1,
      FUNC_CURR = 2'h2,
      FUNC_RES  = 2'h3
   } oplm_func_t;

   typedef enum logic [1:0] {
      SENS_THERMISTOR                    = 2'h0,
      SENS_RESISTANCE_THERMOMETER_SENSOR = 2'h1,
      SENS_VOLT_SOLID_STATE              = 2'h2,
      SENS_CURR_SOLID_STATE              = 2'h3
   } oplm_sens_t;

   typedef struct packed {
      logic                  vld;
      logic                  below;
      logic                  above;
   } oplm_cmp_state_t;

   typedef struct packed {
      logic [EVT_W-1:0]      evt;
      logic [EVT_W-1:0]      mask;
      logic                  out_en;
      oplm_func_t            func;
      oplm_sens_t            sens;
      logic                  on_refused;
      logic                  wr_reject;
      logic                  temp_viol;
      logic                  res_viol;
      logic [31:0]           temp_lo;
      logic [31:0]           temp_hi;
      logic [31:0]           volt_lim;
      logic [31:0]           curr_lim;
      logic [31:0]           res_lo;
      logic [31:0]           res_hi;
      logic [31:0]           setp;
      logic [31:0]           meas_temp;
      logic [31:0]           meas_volt;
      logic [31:0]           meas_curr;
      logic [31:0]           meas_res;
      logic                  pready;
      logic                  pslverr;
      logic [31:0]           prdata;
      logic                  irq;
   } oplm_state_t;
endpackage : oplm_pkg

// ==== design/oplm_top.sv ====
// How it works
// - temperature limits accepted only in -50..250 C
// - below lower temperature sets bit one
// - above upper temperature sets bit zero
// - temperature violation forces output off, blocks on
// - reject crossed lower/upper limits for temperature, resistance
// - reject setpoint outside temperature/resistance limits or above voltage/current limit
// - voltage limit 0.5..10.5 V, default 10.5 V
// - over-voltage sets bit two, output untouched
// - current limit 1..5.25 A, default 2 A
// - current overflow sets bit three, output untouched
// - resistance limits only for thermistor or resistance thermometer
// - below lower resistance sets bit five
// - above upper resistance sets bit four
// - resistance violation forces output off, blocks on
// - each flag individually enabled onto service request
// - output clamped to voltage and current limits
`timescale 1ns/1ps
module oplm_top (
   input  wire logic        i_core_clk,
   input  wire logic        i_srst,
   input  wire logic        i_psel,
   input  wire logic        i_penable,
   input  wire logic        i_pwrite,
   input  wire logic [7:0]  i_paddr,
   input  wire logic [31:0] i_pwdata,
   output logic      [31:0] o_prdata,
   output logic             o_pready,
   output logic             o_pslverr,
   input  wire logic        i_meas_vld,
   input  wire logic [31:0] i_meas_temp,
   input  wire logic [31:0] i_meas_volt,
   input  wire logic [31:0] i_meas_curr,
   input  wire logic [31:0] i_meas_res,
   output logic             o_irq,
   output logic             o_out_en,
   output logic      [31:0] o_volt_clamp,
   output logic      [31:0] o_curr_clamp
);
   oplm_pkg::oplm_state_t st_ff;
   oplm_pkg::oplm_state_t nxt_st;

   oplm_cmp_if #(.W(32)) cmp_if [oplm_pkg::NUM_CH] ();

   function automatic logic [31:0] oplm_abs(input logic [31:0] v);
      oplm_abs = v[31] ? 32'(-$signed(v)) : v;
   endfunction : oplm_abs

   function automatic logic in_rng(input logic [31:0] v,
                                   input logic [31:0] lo,
                                   input logic [31:0] hi);
      in_rng = ($signed(v) >= $signed(lo)) && ($signed(v) <= $signed(hi));
   endfunction : in_rng

   genvar g;
   generate
      for (g = 0; g < oplm_pkg::NUM_CH; g++) begin : g_cmp
         oplm_cmp u_cmp (
            .i_core_clk (i_core_clk),
            .i_srst     (i_srst),
            .bus        (cmp_if[g])
         );
      end
   endgenerate

   assign cmp_if[oplm_pkg::CH_TEMP].vld   = i_meas_vld;
   assign cmp_if[oplm_pkg::CH_TEMP].value = i_meas_temp;
   assign cmp_if[oplm_pkg::CH_TEMP].lo    = st_ff.temp_lo;
   assign cmp_if[oplm_pkg::CH_TEMP].hi    = st_ff.temp_hi;
   // voltage and current only have a magnitude limit, so the floor is unreachable
   assign cmp_if[oplm_pkg::CH_VOLT].vld   = i_meas_vld;
   assign cmp_if[oplm_pkg::CH_VOLT].value = oplm_abs(i_meas_volt);
   assign cmp_if[oplm_pkg::CH_VOLT].lo    = oplm_pkg::SIGNED_MIN;
   assign cmp_if[oplm_pkg::CH_VOLT].hi    = st_ff.volt_lim;
   assign cmp_if[oplm_pkg::CH_CURR].vld   = i_meas_vld;
   assign cmp_if[oplm_pkg::CH_CURR].value = oplm_abs(i_meas_curr);
   assign cmp_if[oplm_pkg::CH_CURR].lo    = oplm_pkg::SIGNED_MIN;
   assign cmp_if[oplm_pkg::CH_CURR].hi    = st_ff.curr_lim;
   assign cmp_if[oplm_pkg::CH_RES].vld    = i_meas_vld;
   assign cmp_if[oplm_pkg::CH_RES].value  = i_meas_res;
   assign cmp_if[oplm_pkg::CH_RES].lo     = st_ff.res_lo;
   assign cmp_if[oplm_pkg::CH_RES].hi     = st_ff.res_hi;

   logic                        cmp_vld;
   logic                        t_below;
   logic                        t_above;
   logic                        v_above;
   logic                        i_above;
   logic                        r_below;
   logic                        r_above;
   assign cmp_vld = cmp_if[oplm_pkg::CH_TEMP].out_vld;
   assign t_below = cmp_if[oplm_pkg::CH_TEMP].below;
   assign t_above = cmp_if[oplm_pkg::CH_TEMP].above;
   assign v_above = cmp_if[oplm_pkg::CH_VOLT].above;
   assign i_above = cmp_if[oplm_pkg::CH_CURR].above;
   assign r_below = cmp_if[oplm_pkg::CH_RES].below;
   assign r_above = cmp_if[oplm_pkg::CH_RES].above;

   logic                        access;
   logic                        commit;
   logic                        mapped;
   logic                        wr_ok;
   logic [31:0]                 rd_val;
   logic [oplm_pkg::EVT_W-1:0]  evt_set;
   logic [oplm_pkg::EVT_W-1:0]  evt_clr;
   logic                        res_active;
   logic                        sp_ok;

   // register decode and write checks
   always_comb begin
      mapped = 1'b1;
      wr_ok  = 1'b1;
      rd_val = '0;
      sp_ok  = 1'b1;
      case (st_ff.func)
         oplm_pkg::FUNC_TEMP: begin
            sp_ok = in_rng(i_pwdata, st_ff.temp_lo, st_ff.temp_hi);
         end
         oplm_pkg::FUNC_VOLT: begin
            sp_ok = $signed(i_pwdata) <= $signed(st_ff.volt_lim);
         end
         oplm_pkg::FUNC_CURR: begin
            sp_ok = $signed(i_pwdata) <= $signed(st_ff.curr_lim);
         end
         default: begin
            sp_ok = in_rng(i_pwdata, st_ff.res_lo, st_ff.res_hi);
         end
      endcase
      case (i_paddr)
         oplm_pkg::OFS_CTRL: begin
            rd_val[oplm_pkg::CTRL_OUT_ON]                        = st_ff.out_en;
            rd_val[oplm_pkg::CTRL_FUNC_LSB +: 2]                 = st_ff.func;
            rd_val[oplm_pkg::CTRL_SENS_LSB +: 2]                 = st_ff.sens;
         end
         oplm_pkg::OFS_STAT: begin
            rd_val[oplm_pkg::STAT_OUT_ON]     = st_ff.out_en;
            rd_val[oplm_pkg::STAT_TEMP_VIOL]  = st_ff.temp_viol;
            rd_val[oplm_pkg::STAT_RES_VIOL]   = st_ff.res_viol;
            rd_val[oplm_pkg::STAT_ON_REFUSED] = st_ff.on_refused;
            rd_val[oplm_pkg::STAT_WR_REJECT]  = st_ff.wr_reject;
         end
         oplm_pkg::OFS_EVT: begin
            rd_val[oplm_pkg::EVT_W-1:0] = st_ff.evt;
         end
         oplm_pkg::OFS_MASK: begin
            rd_val[oplm_pkg::EVT_W-1:0] = st_ff.mask;
         end
         oplm_pkg::OFS_TEMP_LO: begin
            rd_val = st_ff.temp_lo;
            wr_ok  = in_rng(i_pwdata, oplm_pkg::TEMP_MIN, oplm_pkg::TEMP_MAX)
                     && ($signed(i_pwdata) <= $signed(st_ff.temp_hi));
         end
         oplm_pkg::OFS_TEMP_HI: begin
            rd_val = st_ff.temp_hi;
            wr_ok  = in_rng(i_pwdata, oplm_pkg::TEMP_MIN, oplm_pkg::TEMP_MAX)
                     && ($signed(i_pwdata) >= $signed(st_ff.temp_lo));
         end
         oplm_pkg::OFS_VOLT_LIM: begin
            rd_val = st_ff.volt_lim;
            wr_ok  = in_rng(i_pwdata, oplm_pkg::VOLT_MIN, oplm_pkg::VOLT_MAX);
         end
         oplm_pkg::OFS_CURR_LIM: begin
            rd_val = st_ff.curr_lim;
            wr_ok  = in_rng(i_pwdata, oplm_pkg::CURR_MIN, oplm_pkg::CURR_MAX);
         end
         oplm_pkg::OFS_RES_LO: begin
            rd_val = st_ff.res_lo;
            wr_ok  = !i_pwdata[31] && (i_pwdata <= st_ff.res_hi);
         end
         oplm_pkg::OFS_RES_HI: begin
            rd_val = st_ff.res_hi;
            wr_ok  = !i_pwdata[31] && (i_pwdata >= st_ff.res_lo);
         end
         oplm_pkg::OFS_SETP: begin
            rd_val = st_ff.setp;
            wr_ok  = sp_ok;
         end
         oplm_pkg::OFS_MEAS_TEMP: begin
            rd_val = st_ff.meas_temp;
         end
         oplm_pkg::OFS_MEAS_VOLT: begin
            rd_val = st_ff.meas_volt;
         end
         oplm_pkg::OFS_MEAS_CURR: begin
            rd_val = st_ff.meas_curr;
         end
         oplm_pkg::OFS_MEAS_RES: begin
            rd_val = st_ff.meas_res;
         end
         default: begin
            mapped = 1'b0;
         end
      endcase
   end

   assign access = i_psel && i_penable;
   // writes land only on the edge that completes the access phase
   assign commit = access && st_ff.pready && i_pwrite && mapped && wr_ok;

   // resistance checks only make sense for resistive sensors
   assign res_active = (st_ff.sens == oplm_pkg::SENS_THERMISTOR)
                    || (st_ff.sens == oplm_pkg::SENS_RESISTANCE_THERMOMETER_SENSOR);

   always_comb begin
      evt_set = '0;
      if (cmp_vld) begin
         evt_set[oplm_pkg::BIT_OVER_TEMP]  = t_above;
         evt_set[oplm_pkg::BIT_UNDER_TEMP] = t_below;
         evt_set[oplm_pkg::BIT_OVER_VOLT]  = v_above;
         evt_set[oplm_pkg::BIT_CURR_OVFL]  = i_above;
         evt_set[oplm_pkg::BIT_OVER_RES]   = res_active && r_above;
         evt_set[oplm_pkg::BIT_UNDER_RES]  = res_active && r_below;
      end
   end

   always_comb begin
      evt_clr = '0;
      if (commit && (i_paddr == oplm_pkg::OFS_EVT)) begin
         evt_clr = i_pwdata[oplm_pkg::EVT_W-1:0];
      end
   end

   always_comb begin
      nxt_st = st_ff;
      // set beats clear so an event in the clearing cycle survives
      nxt_st.evt = (st_ff.evt & ~evt_clr) | evt_set;
      // the buses only carry the set during the pulse, so latch it then
      if (i_meas_vld) begin
         nxt_st.meas_temp = i_meas_temp;
         nxt_st.meas_volt = i_meas_volt;
         nxt_st.meas_curr = i_meas_curr;
         nxt_st.meas_res  = i_meas_res;
      end
      if (cmp_vld) begin
         nxt_st.temp_viol = t_above || t_below;
         nxt_st.res_viol  = res_active && (r_above || r_below);
      end
      // apb: one wait state, then answer for one cycle
      if (access && !st_ff.pready) begin
         nxt_st.pready  = 1'b1;
         nxt_st.prdata  = i_pwrite ? '0 : rd_val;
         nxt_st.pslverr = !mapped || (i_pwrite && !wr_ok);
      end else begin
         nxt_st.pready  = 1'b0;
         nxt_st.pslverr = 1'b0;
         nxt_st.prdata  = '0;
      end
      if (access && st_ff.pready && i_pwrite && mapped && !wr_ok) begin
         nxt_st.wr_reject = 1'b1;
      end
      if (commit) begin
         case (i_paddr)
            oplm_pkg::OFS_CTRL: begin
               nxt_st.func       = oplm_pkg::oplm_func_t'(i_pwdata[oplm_pkg::CTRL_FUNC_LSB +: 2]);
               nxt_st.sens       = oplm_pkg::oplm_sens_t'(i_pwdata[oplm_pkg::CTRL_SENS_LSB +: 2]);
               nxt_st.on_refused = 1'b0;
               nxt_st.wr_reject  = 1'b0;
               if (!i_pwdata[oplm_pkg::CTRL_OUT_ON]) begin
                  nxt_st.out_en = 1'b0;
               end else if (st_ff.temp_viol || st_ff.res_viol) begin
                  nxt_st.out_en     = 1'b0;
                  nxt_st.on_refused = 1'b1;
               end else begin
                  nxt_st.out_en = 1'b1;
               end
               if (i_pwdata[oplm_pkg::CTRL_DEFAULTS]) begin
                  nxt_st.out_en   = 1'b0;
                  nxt_st.temp_lo  = oplm_pkg::TEMP_LO_DEF;
                  nxt_st.temp_hi  = oplm_pkg::TEMP_HI_DEF;
                  nxt_st.volt_lim = oplm_pkg::VOLT_LIM_DEF;
                  nxt_st.curr_lim = oplm_pkg::CURR_LIM_DEF;
                  nxt_st.res_lo   = oplm_pkg::RES_LO_DEF;
                  nxt_st.res_hi   = oplm_pkg::RES_HI_DEF;
                  nxt_st.setp     = oplm_pkg::SETP_DEF;
               end
            end
            oplm_pkg::OFS_MASK: begin
               nxt_st.mask = i_pwdata[oplm_pkg::EVT_W-1:0];
            end
            oplm_pkg::OFS_TEMP_LO: begin
               nxt_st.temp_lo = i_pwdata;
            end
            oplm_pkg::OFS_TEMP_HI: begin
               nxt_st.temp_hi = i_pwdata;
            end
            oplm_pkg::OFS_VOLT_LIM: begin
               nxt_st.volt_lim = i_pwdata;
            end
            oplm_pkg::OFS_CURR_LIM: begin
               nxt_st.curr_lim = i_pwdata;
            end
            oplm_pkg::OFS_RES_LO: begin
               nxt_st.res_lo = i_pwdata;
            end
            oplm_pkg::OFS_RES_HI: begin
               nxt_st.res_hi = i_pwdata;
            end
            oplm_pkg::OFS_SETP: begin
               nxt_st.setp = i_pwdata;
            end
            default: begin
               nxt_st.setp = st_ff.setp;
            end
         endcase
      end
      // a live violation overrides any enable, including one just granted
      if (nxt_st.temp_viol || nxt_st.res_viol) begin
         nxt_st.out_en = 1'b0;
      end
      nxt_st.irq = |(nxt_st.evt & nxt_st.mask);
   end

   always_ff @(posedge i_core_clk) begin
      if (i_srst) begin
         st_ff          <= '0;
         st_ff.temp_lo  <= oplm_pkg::TEMP_LO_DEF;
         st_ff.temp_hi  <= oplm_pkg::TEMP_HI_DEF;
         st_ff.volt_lim <= oplm_pkg::VOLT_LIM_DEF;
         st_ff.curr_lim <= oplm_pkg::CURR_LIM_DEF;
         st_ff.res_lo   <= oplm_pkg::RES_LO_DEF;
         st_ff.res_hi   <= oplm_pkg::RES_HI_DEF;
         st_ff.setp     <= oplm_pkg::SETP_DEF;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign o_prdata     = st_ff.prdata;
   assign o_pready     = st_ff.pready;
   assign o_pslverr    = st_ff.pslverr;
   assign o_irq        = st_ff.irq;
   assign o_out_en     = st_ff.out_en;
   // the power stage treats these as hard ceilings on |V| and |I|
   assign o_volt_clamp = st_ff.volt_lim;
   assign o_curr_clamp = st_ff.curr_lim;
endmodule : oplm_top

// ==== dv/oplm_chk.sv ====
`timescale 1ns/1ps
module oplm_chk (
   input wire logic        i_core_clk,
   input wire logic        i_srst,
   input wire logic        i_psel,
   input wire logic        i_penable,
   input wire logic        i_pwrite,
   input wire logic [7:0]  i_paddr,
   input wire logic [31:0] i_pwdata,
   input wire logic [31:0] o_prdata,
   input wire logic        o_pready,
   input wire logic        o_pslverr,
   input wire logic        i_meas_vld,
   input wire logic [31:0] i_meas_temp,
   input wire logic        o_irq,
   input wire logic        o_out_en,
   input wire logic [31:0] o_volt_clamp
);
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (i_srst);
   logic wr_done;
   assign wr_done = o_pready && i_pwrite;
   pready_pulse_a: assert property (o_pready |=> !o_pready) else $error("pready too long");
   access_answer_a: assert property (i_psel && i_penable && !o_pready |=> o_pready)
      else $error("no answer one cycle into access");
   rdata_idle_a: assert property (!o_pready |-> o_prdata == 32'h0) else $error("stray rdata");
   unmapped_err_a: assert property (i_psel && i_penable && !o_pready
      && i_paddr > oplm_pkg::OFS_MEAS_RES |=> o_pslverr) else $error("unmapped not refused");
   over_temp_off_a: assert property (
      i_meas_vld && $signed(i_meas_temp) > $signed(oplm_pkg::TEMP_MAX) |-> ##2 !o_out_en)
      else $error("output on after over temperature");
   under_temp_off_a: assert property (
      i_meas_vld && $signed(i_meas_temp) < $signed(oplm_pkg::TEMP_MIN) |-> ##2 !o_out_en)
      else $error("output on after under temperature");
   out_on_cause_a: assert property (
      $rose(o_out_en) |-> $past(wr_done && i_paddr == oplm_pkg::OFS_CTRL && i_pwdata[0]))
      else $error("output on without request");
   out_off_cause_a: assert property ($fell(o_out_en) |-> $past(i_meas_vld, 2)
      || $past(wr_done && i_paddr == oplm_pkg::OFS_CTRL) || $past(i_srst))
      else $error("output off without cause");
   irq_fall_a: assert property ($fell(o_irq) |-> $past(i_srst) || $past(wr_done
      && (i_paddr == oplm_pkg::OFS_EVT || i_paddr == oplm_pkg::OFS_MASK)))
      else $error("irq dropped without clear");
   irq_rise_a: assert property ($rose(o_irq) |-> $past(i_meas_vld, 2)
      || $past(wr_done && i_paddr == oplm_pkg::OFS_MASK)) else $error("irq without cause");
   clamp_hold_a: assert property (
      !$stable(o_volt_clamp) |-> $past(wr_done) || $past(i_srst))
      else $error("voltage clamp moved without write");
   cover property (o_pslverr);
   cover property ($fell(o_out_en));
   cover property ($rose(o_irq));
endmodule : oplm_chk
bind oplm_top oplm_chk u_chk (.i_core_clk, .i_srst, .i_psel, .i_penable, .i_pwrite, .i_paddr,
   .i_pwdata, .o_prdata, .o_pready, .o_pslverr, .i_meas_vld, .i_meas_temp, .o_irq,
   .o_out_en, .o_volt_clamp);

// ==== dv/oplm_tec_model.sv ====
`timescale 1ns/1ps
module oplm_tec_model (
   input  wire logic   i_core_clk,
   output logic        o_vld,
   output logic [31:0] o_temp,
   output logic [31:0] o_volt,
   output logic [31:0] o_curr,
   output logic [31:0] o_res
);
   initial begin
      o_vld = 1'b0;
      {o_temp, o_volt, o_curr, o_res} = '0;
   end
   // lines flip after the pulse so stale data can never pass for a held reading
   task automatic measure(input logic [31:0] t, v, c, r);
      @(posedge i_core_clk);
      o_vld <= 1'b1;
      {o_temp, o_volt, o_curr, o_res} <= {t, v, c, r};
      @(posedge i_core_clk);
      o_vld <= 1'b0;
      {o_temp, o_volt, o_curr, o_res} <= ~{t, v, c, r};
   endtask : measure
endmodule : oplm_tec_model

// ==== dv/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
   typedef struct packed {logic [7:0] a; logic [31:0] d; logic e;} oplm_wr_t;
   typedef struct packed {logic [31:0] t, v, c, r; logic [1:0] s; logic [5:0] ev; logic on;} oplm_ev_t;
   logic        i_core_clk, i_srst, i_psel, i_penable, i_pwrite, i_meas_vld;
   logic [7:0]  i_paddr;
   logic [31:0] i_pwdata, o_prdata, i_meas_temp, i_meas_volt, i_meas_curr, i_meas_res;
   logic        o_pready, o_pslverr, o_irq, o_out_en, err;
   logic [31:0] o_volt_clamp, o_curr_clamp, rd;
   int          n_errors, compares;
   oplm_wr_t    lim [13] = '{
      '{8'h10, 32'hffff3caf, 1'b1}, '{8'h14, 32'h0003d091, 1'b1},
      '{8'h10, 32'h00000000, 1'b0}, '{8'h14, 32'hffffff9c, 1'b1},
      '{8'h18, 32'h000001f3, 1'b1}, '{8'h18, 32'h00002905, 1'b1},
      '{8'h18, 32'h000001f4, 1'b0}, '{8'h1c, 32'h000003e7, 1'b1},
      '{8'h1c, 32'h00001483, 1'b1}, '{8'h1c, 32'h00001482, 1'b0},
      '{8'h24, 32'h000003e7, 1'b1}, '{8'h20, 32'h0bebc201, 1'b1},
      '{8'h28, 32'h0003d091, 1'b1}};
   oplm_ev_t    evs [8] = '{
      '{32'h0003f7a0, 32'h3e8, 32'h1f4, 32'h186a0, 2'h0, 6'h01, 1'b0},
      '{32'hffff15a0, 32'h3e8, 32'h1f4, 32'h186a0, 2'h0, 6'h02, 1'b0},
      '{32'h61a8, 32'hffffd508, 32'h1f4, 32'h186a0, 2'h0, 6'h04, 1'b1},
      '{32'h61a8, 32'h3e8, 32'h9c4, 32'h186a0, 2'h0, 6'h08, 1'b1},
      '{32'h61a8, 32'h3e8, 32'h1f4, 32'h0ee6b280, 2'h0, 6'h10, 1'b0},
      '{32'h61a8, 32'h3e8, 32'h1f4, 32'h1f4, 2'h0, 6'h20, 1'b0},
      '{32'h61a8, 32'h3e8, 32'h1f4, 32'h1f4, 2'h2, 6'h00, 1'b1},
      '{32'h61a8, 32'h3e8, 32'h1f4, 32'h0ee6b280, 2'h1, 6'h10, 1'b0}};
   oplm_top dut (.i_core_clk, .i_srst, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata,
      .o_prdata, .o_pready, .o_pslverr, .i_meas_vld, .i_meas_temp, .i_meas_volt, .i_meas_curr,
      .i_meas_res, .o_irq, .o_out_en, .o_volt_clamp, .o_curr_clamp);
   oplm_tec_model tec (.i_core_clk, .o_vld(i_meas_vld), .o_temp(i_meas_temp),
      .o_volt(i_meas_volt), .o_curr(i_meas_curr), .o_res(i_meas_res));
   initial begin
      i_core_clk = 1'b0;
      forever #5 i_core_clk = ~i_core_clk;
   end
   task automatic check(input string what, input logic [31:0] seen, exp);
      compares++;
      if (seen !== exp) begin
         n_errors++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic stop_test;
      $display("compares %0d mismatches %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : stop_test
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      i_psel <= 1'b1;
      i_pwrite <= w;
      i_paddr <= a;
      i_pwdata <= d;
      @(posedge i_core_clk);
      i_penable <= 1'b1;
      @(posedge i_core_clk);
      while (o_pready !== 1'b1 && n < 20) begin
         n++;
         @(posedge i_core_clk);
      end
      rd = o_prdata;
      err = o_pslverr;
      i_psel <= 1'b0;
      i_penable <= 1'b0;
      if (n == 20) n_errors++;
      @(posedge i_core_clk);
   endtask : apb
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic e);
      apb(1'b1, a, d);
      check("pslverr", {31'h0, err}, {31'h0, e});
   endtask : wr
   task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      check(what, rd, exp);
   endtask : rdchk
   task automatic meas(input logic [31:0] t, v, c, r);
      tec.measure(t, v, c, r);
      repeat (3) @(posedge i_core_clk);
   endtask : meas
   task automatic t_limits;
      rdchk("unmapped", 8'h40, 32'h0);
      check("unmapped err", {31'h0, err}, 32'h1);
      foreach (lim[i]) wr(lim[i].a, lim[i].d, lim[i].e);
      rdchk("kept temp lo", 8'h10, 32'h0);
      check("volt clamp", o_volt_clamp, 32'h1f4);
      wr(8'h00, 32'h2, 1'b0);
      rdchk("volt default", 8'h18, 32'h2904);
      rdchk("curr default", 8'h1c, 32'h7d0);
      check("curr clamp", o_curr_clamp, 32'h7d0);
      wr(8'h0c, 32'h3f, 1'b0);
      $display("test limits done");
   endtask : t_limits
   task automatic t_events;
      foreach (evs[i]) begin
         meas(32'h61a8, 32'h3e8, 32'h1f4, 32'h186a0);
         wr(8'h08, 32'h3f, 1'b0);
         wr(8'h00, {26'h0, evs[i].s, 4'h1}, 1'b0);
         check("out on", {31'h0, o_out_en}, 32'h1);
         meas(evs[i].t, evs[i].v, evs[i].c, evs[i].r);
         rdchk("events", 8'h08, {26'h0, evs[i].ev});
         check("out after", {31'h0, o_out_en}, {31'h0, evs[i].on});
         check("irq", {31'h0, o_irq}, {31'h0, |evs[i].ev});
         wr(8'h00, {26'h0, evs[i].s, 4'h1}, 1'b0);
         check("on refused", {31'h0, o_out_en}, {31'h0, evs[i].on});
         meas(32'h61a8, 32'h3e8, 32'h1f4, 32'h186a0);
         rdchk("sticky", 8'h08, {26'h0, evs[i].ev});
      end
      $display("test events done");
   endtask : t_events
   task automatic t_mask;
      meas(32'h0003f7a0, 32'h3e8, 32'h1f4, 32'h186a0);
      rdchk("meas temp", 8'h2c, 32'h0003f7a0);
      rdchk("status", 8'h04, 32'h0000000a);
      wr(8'h0c, 32'h02, 1'b0);
      check("masked irq", {31'h0, o_irq}, 32'h0);
      wr(8'h0c, 32'h01, 1'b0);
      check("unmasked irq", {31'h0, o_irq}, 32'h1);
      wr(8'h08, 32'h01, 1'b0);
      check("cleared irq", {31'h0, o_irq}, 32'h0);
      $display("test mask done");
   endtask : t_mask
   initial begin
      {i_srst, i_psel, i_penable, i_pwrite, i_paddr, i_pwdata} = {1'b1, 43'h0};
      n_errors = 0;
      compares = 0;
      repeat (8) @(posedge i_core_clk);
      i_srst <= 1'b0;
      @(posedge i_core_clk);
      t_limits();
      t_events();
      t_mask();
      stop_test();
   end
   initial begin
      #200000;
      n_errors++;
      stop_test();
   end
endmodule : tb_top
